// *** rtl/sabcr_defs.svh ***
// Timing counts and field sizes for the converter serial readout
`ifndef SABCR_DEFS_SVH
`define SABCR_DEFS_SVH
`define SABCR_RES_BITS 18
`define SABCR_MIDSCALE 18'h20000
`define SABCR_FULLSCALE 18'h3FFFF
`define SABCR_CONV_NS 1600
`define SABCR_CLK_NS 50
`define SABCR_CONV_CYC ((`SABCR_CONV_NS + `SABCR_CLK_NS - 1) / `SABCR_CLK_NS)
`define SABCR_SCLK_HALF 4
`define SABCR_FIFO_DEPTH 8
`endif

// *** rtl/sabcr_pkg.sv ***
// Types shared by both ends of the converter serial readout
package sabcr_pkg;
   typedef enum logic [1:0] {
      SABCR_MODE_WIRE4,
      SABCR_MODE_CHAIN,
      SABCR_MODE_CHAIN_BUSY
   } sabcr_mode_t;
endpackage : sabcr_pkg

// *** rtl/sabcr_link_if.sv ***
// Serial link between converter and host
`timescale 1ns/10ps
interface sabcr_link_if;
   logic conv_start;
   logic chain_in;
   logic sclk;
   logic sdo_out;
   logic sdo_oe;
   modport dev (
      input conv_start,
      input chain_in,
      input sclk,
      output sdo_out,
      output sdo_oe
   );
   modport host (
      output conv_start,
      output chain_in,
      output sclk,
      input sdo_out,
      input sdo_oe
   );
endinterface : sabcr_link_if

// *** rtl/sabcr_fifo.sv ***
// Small valid/ready FIFO
`timescale 1ns/10ps
module sabcr_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic push;
   logic pop;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign in_ready_o = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
   assign out_valid_o = wr_ptr != rd_ptr;
   assign out_data_o = mem[rd_ptr[AW-1:0]];
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_ptr <= '0;
      end else if (push) begin
         wr_ptr <= wr_ptr + 1'b1;
      end
   end
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rd_ptr <= '0;
      end else if (pop) begin
         rd_ptr <= rd_ptr + 1'b1;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data_i;
      end
   end
endmodule : sabcr_fifo

// *** rtl/sabcr_dev.sv ***
// Converter end: conversion timing and serial readout shift register
//
// Operation
// - 4-wire: conv_start rise starts conversion, SDO released.
// - Host holds conv_start high through conversion and readback.
// - conv_start and chain_in both low drive SDO low.
// - Host lowers chain_in early, holds until busy.
// - 4-wire: conversion end drives SDO low.
// - Shift MSB first on falls; release after 19th.
// - chain_in low at conv_start rise selects chain.
// - SCLK at conv_start rise selects busy option.
// - Chain mode always drives SDO.
// - Low SDO pulls next chain_in low.
// - conv_start low-high pulse starts conversion everywhere.
// - Chain no busy: MSB out, then shift on falls.
// - Chain: chain_in shifts in on each fall except the first fall in busy mode.
// - Host gives 18 times N clocks; the host here gives 18 in chain mode and 19 in the other modes.
// - chain_in may be tied to conv_start.
// - Chain busy needs own done and upstream busy.
// - Busy bit not chained on first fall.
// - Result is offset-binary, midscale 20000.
// - Host captures SDO on falling SCLK.
`timescale 1ns/10ps
`include "sabcr_defs.svh"
module sabcr_dev #(
   parameter int RES_BITS = `SABCR_RES_BITS,
   parameter int CONV_CYC = `SABCR_CONV_CYC
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Link
   sabcr_link_if.dev link,
   // Conversion engine
   input wire logic [RES_BITS-1:0] sample_i,
   output logic converting_o,
   output sabcr_pkg::sabcr_mode_t mode_o
);
   import sabcr_pkg::*;
   initial begin
      if (RES_BITS < 2 || CONV_CYC < 1) $error("Bad parameters");
   end
   typedef enum logic [1:0] {SABCR_IDLE, SABCR_CONV, SABCR_READ} sabcr_dev_state_t;
   ////////////////////////////////////////////////////////////////////
   // Two-flop input synchronisers
   logic [2:0] meta;
   logic [2:0] sync;
   logic cs_d;
   logic ck_d;
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta <= 3'h0;
         sync <= 3'h0;
      end else begin
         meta <= {link.conv_start, link.chain_in, link.sclk};
         sync <= meta;
      end
   end
   logic cs_s;
   logic ci_s;
   logic ck_s;
   assign cs_s = sync[2];
   assign ci_s = sync[1];
   assign ck_s = sync[0];
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cs_d <= 1'b0;
         ck_d <= 1'b0;
      end else begin
         cs_d <= cs_s;
         ck_d <= ck_s;
      end
   end
   logic cs_rise;
   logic cs_fall;
   logic ck_fall;
   assign cs_rise = cs_s && !cs_d;
   assign cs_fall = !cs_s && cs_d;
   assign ck_fall = !ck_s && ck_d;
   ////////////////////////////////////////////////////////////////////
   // Mode selection and conversion timer
   sabcr_dev_state_t state;
   sabcr_mode_t mode;
   logic [$clog2(CONV_CYC+1)-1:0] conv_cnt;
   logic conv_done;
   assign conv_done = state == SABCR_CONV && conv_cnt == '0;
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode <= SABCR_MODE_WIRE4;
      end else if (cs_rise) begin
         if (ci_s) begin
            mode <= SABCR_MODE_WIRE4;
         end else if (ck_s) begin
            mode <= SABCR_MODE_CHAIN_BUSY;
         end else begin
            mode <= SABCR_MODE_CHAIN;
         end
      end
   end
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= SABCR_IDLE;
         conv_cnt <= '0;
      end else begin
         case (state)
            SABCR_IDLE: begin
               if (cs_rise) begin
                  state <= SABCR_CONV;
                  conv_cnt <= ($clog2(CONV_CYC+1))'(CONV_CYC - 1);
               end
            end
            SABCR_CONV: begin
               if (conv_cnt != '0) begin
                  conv_cnt <= conv_cnt - 1'b1;
               end else begin
                  state <= SABCR_READ;
               end
            end
            SABCR_READ: begin
               if (cs_rise) begin
                  state <= SABCR_CONV;
                  conv_cnt <= ($clog2(CONV_CYC+1))'(CONV_CYC - 1);
               end
            end
            default: state <= SABCR_IDLE;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Readout shift register
   // Extra leading bit is the 4-wire output after each shift; the busy flag comes from chain_busy and the low marker from fall_cnt
   logic [RES_BITS:0] shreg;
   logic [$clog2(RES_BITS+2)-1:0] fall_cnt;
   logic busy_armed;
   logic chain_busy;
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         shreg <= '0;
         fall_cnt <= '0;
      end else if (conv_done) begin
         shreg <= {1'b0, sample_i};
         fall_cnt <= '0;
      end else if (state == SABCR_READ && ck_fall) begin
         if (mode == SABCR_MODE_WIRE4) begin
            shreg <= {shreg[RES_BITS-1:0], 1'b0};
         end else if (mode == SABCR_MODE_CHAIN_BUSY && fall_cnt == '0) begin
            // First fall only retires the busy bit, so the MSB must stay put
            shreg <= shreg;
         end else begin
            shreg <= {shreg[RES_BITS-1:0], ci_s};
         end
         if (fall_cnt != '1) begin
            fall_cnt <= fall_cnt + 1'b1;
         end
      end
   end
   // Busy waits for own completion and upstream busy on chain_in
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         busy_armed <= 1'b0;
         chain_busy <= 1'b0;
      end else if (cs_rise) begin
         busy_armed <= 1'b0;
         chain_busy <= 1'b0;
      end else begin
         if (conv_done && mode == SABCR_MODE_CHAIN_BUSY) begin
            busy_armed <= 1'b1;
         end
         if (ck_fall) begin
            busy_armed <= 1'b0;
            chain_busy <= 1'b0;
         end else if (busy_armed && (ci_s || cs_s == ci_s && ci_s)) begin
            chain_busy <= 1'b1;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////
   // SDO drive
   logic sdo;
   logic oe;
   logic wire4_read;
   assign wire4_read = state == SABCR_READ && mode == SABCR_MODE_WIRE4
                       && fall_cnt < ($clog2(RES_BITS+2))'(RES_BITS + 1) && !cs_rise;
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sdo <= 1'b0;
         oe <= 1'b0;
      end else if (mode != SABCR_MODE_WIRE4 && !(cs_rise && ci_s)) begin
         oe <= 1'b1;
         if (state == SABCR_CONV || cs_rise) begin
            sdo <= 1'b0;
         end else if (!cs_s && !ci_s) begin
            // Also after readout, or stale shifted-in bits would leak downstream
            sdo <= 1'b0;
         end else if (busy_armed) begin
            sdo <= chain_busy;
         end else begin
            sdo <= shreg[RES_BITS-1];
         end
      end else if (!cs_s && !ci_s) begin
         oe <= 1'b1;
         sdo <= 1'b0;
      end else if (wire4_read) begin
         oe <= 1'b1;
         sdo <= fall_cnt == '0 ? 1'b0 : shreg[RES_BITS];
      end else begin
         oe <= 1'b0;
         sdo <= 1'b0;
      end
   end
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         converting_o <= 1'b0;
         mode_o <= SABCR_MODE_WIRE4;
      end else begin
         converting_o <= state == SABCR_CONV;
         mode_o <= mode;
      end
   end
   assign link.sdo_out = sdo;
   assign link.sdo_oe = oe;
   logic unused;
   assign unused = cs_fall;
endmodule : sabcr_dev

// *** rtl/sabcr_host.sv ***
// Host end: starts conversions, clocks out results into a FIFO
`timescale 1ns/10ps
`include "sabcr_defs.svh"
module sabcr_host #(
   parameter int RES_BITS = `SABCR_RES_BITS,
   parameter int CONV_CYC = `SABCR_CONV_CYC,
   parameter int SCLK_HALF = `SABCR_SCLK_HALF,
   parameter int FIFO_DEPTH = `SABCR_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Link
   sabcr_link_if.host link,
   // User request
   input wire logic start_i,
   input wire sabcr_pkg::sabcr_mode_t mode_i,
   output logic idle_o,
   // Result stream
   output logic res_valid_o,
   input wire logic res_ready_i,
   output logic [RES_BITS-1:0] res_data_o
);
   import sabcr_pkg::*;
   initial begin
      if (SCLK_HALF < 1 || RES_BITS < 2) $error("Bad parameters");
   end
   typedef enum logic [2:0] {
      SABCR_H_IDLE, SABCR_H_LOW, SABCR_H_WAIT, SABCR_H_CLK, SABCR_H_PUSH
   } sabcr_host_state_t;
   ////////////////////////////////////////////////////////////////////
   logic [1:0] sdo_meta;
   logic [1:0] sdo_sync;
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sdo_meta <= 2'h0;
         sdo_sync <= 2'h0;
      end else begin
         sdo_meta <= {link.sdo_out, link.sdo_oe};
         sdo_sync <= sdo_meta;
      end
   end
   ////////////////////////////////////////////////////////////////////
   sabcr_host_state_t state;
   sabcr_mode_t mode;
   logic cs;
   logic ci;
   logic ck;
   logic [15:0] cnt;
   logic [5:0] falls;
   logic [RES_BITS-1:0] word;
   logic f_ready;
   logic push;
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= SABCR_H_IDLE;
         mode <= SABCR_MODE_WIRE4;
         cs <= 1'b0;
         ci <= 1'b1;
         ck <= 1'b0;
         cnt <= '0;
         falls <= '0;
         word <= '0;
      end else begin
         case (state)
            SABCR_H_IDLE: begin
               if (start_i && f_ready) begin
                  mode <= mode_i;
                  ci <= mode_i == SABCR_MODE_WIRE4;
                  ck <= mode_i == SABCR_MODE_CHAIN_BUSY;
                  cs <= 1'b0;
                  cnt <= 16'(SCLK_HALF * 2);
                  state <= SABCR_H_LOW;
               end
            end
            SABCR_H_LOW: begin
               if (cnt != '0) begin
                  cnt <= cnt - 1'b1;
               end else begin
                  cs <= 1'b1;
                  cnt <= 16'(SCLK_HALF * 2);
                  state <= SABCR_H_WAIT;
               end
            end
            SABCR_H_WAIT: begin
               if (cnt != '0) begin
                  cnt <= cnt - 1'b1;
               end else begin
                  ck <= 1'b0;
                  // Chain busy: chain_in follows conv_start and enables the busy bit
                  ci <= mode == SABCR_MODE_CHAIN_BUSY;
                  if (mode == SABCR_MODE_CHAIN || sdo_sync[0] && sdo_sync[1] == 1'b0
                      && mode == SABCR_MODE_WIRE4 || mode == SABCR_MODE_CHAIN_BUSY
                      && sdo_sync[1]) begin
                     cnt <= 16'(CONV_CYC + 8);
                     falls <= '0;
                     state <= mode == SABCR_MODE_CHAIN ? SABCR_H_PUSH : SABCR_H_CLK;
                  end
               end
            end
            SABCR_H_PUSH: begin
               if (cnt != '0) begin
                  cnt <= cnt - 1'b1;
               end else begin
                  cnt <= 16'(SCLK_HALF);
                  state <= SABCR_H_CLK;
               end
            end
            SABCR_H_CLK: begin
               if (cnt != '0) begin
                  cnt <= cnt - 1'b1;
               end else if (!ck && falls == 6'(RES_BITS + (mode == SABCR_MODE_CHAIN ? 0 : 1))) begin
                  cs <= mode != SABCR_MODE_WIRE4;
                  ci <= mode == SABCR_MODE_WIRE4;
                  state <= SABCR_H_IDLE;
               end else begin
                  cnt <= 16'(SCLK_HALF);
                  ck <= !ck;
                  // Capture at the fall: the bit shifted at the previous fall has settled for four clk_sys_i cycles
                  if (ck) begin
                     falls <= falls + 1'b1;
                     if (mode == SABCR_MODE_CHAIN || falls != '0) begin
                        word <= {word[RES_BITS-2:0], sdo_sync[1]};
                     end
                  end
               end
            end
            default: state <= SABCR_H_IDLE;
         endcase
      end
   end
   assign push = state == SABCR_H_CLK && cnt == '0 && !ck
                 && falls == 6'(RES_BITS + (mode == SABCR_MODE_CHAIN ? 0 : 1));
   sabcr_fifo #(.WIDTH(RES_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .in_valid_i(push),
      .in_ready_o(f_ready),
      .in_data_i(word),
      .out_valid_o(res_valid_o),
      .out_ready_i(res_ready_i),
      .out_data_o(res_data_o)
   );
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         idle_o <= 1'b0;
      end else begin
         idle_o <= state == SABCR_H_IDLE;
      end
   end
   assign link.conv_start = cs;
   assign link.chain_in = ci;
   assign link.sclk = ck;
endmodule : sabcr_host

// *** tb/sabcr_monitor.sv ***
// Link checker watching both ends of the converter serial link
`timescale 1ns/10ps
module sabcr_monitor (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Link
   input wire logic conv_start,
   input wire logic chain_in,
   input wire logic sclk,
   input wire logic sdo_out,
   input wire logic sdo_oe
);
   logic ch;
   logic bz;
   logic seen;
   logic [4:0] age;
   logic [5:0] cnt;
   default clocking dc @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   ////////////////////////////////////////
   // Mode picked at the last conv_start rise
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ch <= 1'b0;
         bz <= 1'b0;
         seen <= 1'b0;
      end else if ($rose(conv_start)) begin
         ch <= ~chain_in;
         bz <= sclk;
         seen <= 1'b1;
      end
   end
   // Cycles since the rise; saturates before any readout can start
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         age <= 5'h00;
      end else if ($rose(conv_start)) begin
         age <= 5'h00;
      end else if (age != 5'h1F) begin
         age <= age + 5'h01;
      end
   end
   // Readout falls only: the busy select fall right after the rise is skipped
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt <= 6'h00;
      end else if ($rose(conv_start)) begin
         cnt <= 6'h00;
      end else if ($fell(sclk) && age == 5'h1F && cnt != 6'h3F) begin
         cnt <= cnt + 6'h01;
      end
   end
   ////////////////////////////////////////
   low_drive_a : assert property (
      (!conv_start && !chain_in)[*5] |-> sdo_oe && !sdo_out)
      else $error("sdo not driven low");
   sdo_release_a : assert property (
      $rose(conv_start) && chain_in |-> ##[1:5] !sdo_oe)
      else $error("sdo not released at start");
   busy_low_a : assert property (
      $rose(conv_start) && chain_in |-> ##[32:45] sdo_oe && !sdo_out)
      else $error("no low busy after conversion");
   wire4_end_a : assert property (
      !ch && $fell(sclk) && age == 5'h1F && cnt == 6'h12 |-> ##[1:6] !sdo_oe)
      else $error("sdo not released after last fall");
   chain_drive_a : assert property (
      ch[*5] |-> sdo_oe)
      else $error("sdo released in chain mode");
   fall_count_a : assert property (
      $rose(conv_start) && seen |-> cnt == ((ch && !bz) ? 6'h12 : 6'h13))
      else $error("wrong number of readout falls");
   busy_gate_a : assert property (
      ch && bz && cnt == 6'h00 && $rose(sdo_out) |-> $past(chain_in, 2) && age == 5'h1F)
      else $error("busy shown too early");
   start_pulse_a : assert property (
      $fell(conv_start) |-> !conv_start[*8])
      else $error("conv_start low pulse too short");
endmodule : sabcr_monitor

// *** tb/sar_adc_busy_and_chain_readout_test.sv ***
// Testbench joining converter and host ends over the serial link
`timescale 1ns/10ps
`include "sabcr_defs.svh"
module sar_adc_busy_and_chain_readout_test;
   import sabcr_pkg::*;
   logic clk_sys_i;
   logic resetn_i;
   logic start;
   sabcr_mode_t mode;
   sabcr_mode_t mode_seen;
   logic converting;
   logic idle;
   logic res_valid;
   logic res_ready;
   logic [17:0] res_data;
   logic [17:0] sample;
   logic cs;
   int bad_count;
   int compares;
   int conv_cycles;
   logic [17:0] vals [4];
   sabcr_link_if link ();
   sabcr_dev i_sabcr_dev (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .link(link),
      .sample_i(sample),
      .converting_o(converting),
      .mode_o(mode_seen)
   );
   sabcr_host i_sabcr_host (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .link(link),
      .start_i(start),
      .mode_i(mode),
      .idle_o(idle),
      .res_valid_o(res_valid),
      .res_ready_i(res_ready),
      .res_data_o(res_data)
   );
   sabcr_monitor i_sabcr_monitor (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .conv_start(link.conv_start),
      .chain_in(link.chain_in),
      .sclk(link.sclk),
      .sdo_out(link.sdo_out),
      .sdo_oe(link.sdo_oe)
   );
   always #25 clk_sys_i = ~clk_sys_i;
   // Cycles with converting high since the last request
   always @(posedge clk_sys_i) begin
      if (start) begin
         conv_cycles <= 0;
      end else if (converting === 1'b1) begin
         conv_cycles <= conv_cycles + 1;
      end
   end
   ////////////////////////////////////////
   task automatic wrap_up;
      if (bad_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up
   task automatic check(input string name, input logic [17:0] got, input logic [17:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   // Bounded wait on idle (which=0) or result valid (which=1)
   task automatic wait_for(input bit which, input logic lvl);
      int n;
      n = 0;
      while ((which ? res_valid : idle) !== lvl) begin
         @(negedge clk_sys_i);
         n++;
         if (n > 2000) begin
            bad_count++;
            wrap_up();
         end
      end
   endtask : wait_for
   // Sample held until done: the device captures it at conversion end
   task automatic convert(input sabcr_mode_t m, input logic [17:0] s);
      mode = m;
      sample = s;
      start = 1'b1;
      wait_for(1'b0, 1'b0);
      start = 1'b0;
      wait_for(1'b0, 1'b1);
      check("conv time", 18'(conv_cycles), 18'(`SABCR_CONV_CYC));
   endtask : convert
   task automatic pop(input logic [17:0] exp);
      wait_for(1'b1, 1'b1);
      check("result", res_data, exp);
      res_ready = 1'b1;
      @(negedge clk_sys_i);
      res_ready = 1'b0;
   endtask : pop
   ////////////////////////////////////////
   initial begin
      clk_sys_i = 1'b0;
      resetn_i = 1'b0;
      start = 1'b0;
      mode = SABCR_MODE_WIRE4;
      sample = 18'h00000;
      res_ready = 1'b0;
      bad_count = 0;
      compares = 0;
      vals = '{18'h00000, `SABCR_MIDSCALE, `SABCR_FULLSCALE, 18'h15A5A};
      repeat (5) @(negedge clk_sys_i);
      resetn_i = 1'b1;
      @(negedge clk_sys_i);
      // Every mode with the code extremes, back to back
      for (int m = 0; m < 3; m++) begin
         for (int k = 0; k < 4; k++) begin
            convert(sabcr_mode_t'(m), vals[k]);
            check("mode", 18'(mode_seen), 18'(m));
            pop(vals[k]);
         end
      end
      // Fill the buffer with the drain side stalled
      for (int k = 0; k < 8; k++) begin
         convert(SABCR_MODE_CHAIN, 18'h00100 + 18'(k));
      end
      start = 1'b1;
      cs = link.conv_start;
      repeat (60) begin
         @(negedge clk_sys_i);
         check("refused", 18'(link.conv_start), 18'(cs));
      end
      start = 1'b0;
      for (int k = 0; k < 8; k++) begin
         pop(18'h00100 + 18'(k));
      end
      check("empty", 18'(res_valid), 18'h00000);
      wrap_up();
   end
endmodule : sar_adc_busy_and_chain_readout_test
